/* File: rtl/gpc_regs.svh */
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// Number of general-purpose pins in the bank.
`define GPC_NPINS 17

// Byte offsets of the registers on the bus.
`define GPC_OFS_OUT 8'h00
`define GPC_OFS_OE 8'h04
`define GPC_OFS_IN 8'h08
`define GPC_OFS_PULLUP 8'h0c
`define GPC_OFS_PULLDN 8'h10
`define GPC_OFS_FUNC 8'h14
`define GPC_OFS_HOLD 8'h18
`define GPC_OFS_KEEP 8'h1c
`define GPC_OFS_LVL 8'h20
`define GPC_OFS_POL 8'h24
`define GPC_OFS_STAT 8'h28
`define GPC_OFS_MASK 8'h2c
`define GPC_OFS_CTRL 8'h30

// Field position of the sleep output-enable kill in the control register.
`define GPC_CTRL_KILL_BIT 0

// Reset value of every writable register.
`define GPC_RST_VAL 32'h0000_0000

`endif

/* File: rtl/gpc_pkg.sv */
package gpc_pkg;

  // Resistor setting applied to one pad.
  typedef enum logic [1:0] {
    GPC_PULL_NONE = 2'h0,
    GPC_PULL_UP = 2'h1,
    GPC_PULL_DOWN = 2'h2
  } gpc_pull_t;

endpackage : gpc_pkg

/* File: rtl/gpc_pin.sv */
`timescale 1ns/1ps
`default_nettype none

// One pad slice: input synchroniser, event detection and output staging.
module gpc_pin (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pad_in,
  input wire logic out_bit,
  input wire logic oe_bit,
  input wire logic pu_bit,
  input wire logic pd_bit,
  input wire logic func_bit,
  input wire logic periph_out,
  input wire logic periph_oe,
  input wire logic hold_bit,
  input wire logic keep_bit,
  input wire logic lvl_bit,
  input wire logic pol_bit,
  input wire logic oe_kill,
  output logic pad_out_q,
  output logic pad_oe_q,
  output logic pull_up_q,
  output logic pull_dn_q,
  output logic keep_en_q,
  output logic in_sync_q,
  output logic event_q
);

  // Synchroniser stages and the previous synchronised level.
  logic sync1_q;
  logic prev_q;
  // Selected resistor setting.
  gpc_pkg::gpc_pull_t pull_sel;
  // Source selected for the output and its enable.
  wire logic src_out = func_bit ? periph_out : out_bit;
  wire logic src_oe = func_bit ? periph_oe : oe_bit;
  // Edge and level conditions on the synchronised input.
  wire logic rise = in_sync_q & ~prev_q;
  wire logic fall = ~in_sync_q & prev_q;
  wire logic lvl_hit = (in_sync_q == pol_bit);
  wire logic edge_hit = pol_bit ? rise : fall;

  // Pull-up wins when both resistor bits are set.
  assign pull_sel = pu_bit ? gpc_pkg::GPC_PULL_UP :
                    pd_bit ? gpc_pkg::GPC_PULL_DOWN :
                    gpc_pkg::GPC_PULL_NONE;

  // RULE_10: two-stage synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      in_sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      sync1_q <= pad_in;
      in_sync_q <= sync1_q;
      prev_q <= in_sync_q;
    end
  end

  // RULE_04: edge or level trigger.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else begin
      event_q <= lvl_bit ? lvl_hit : edge_hit;
    end
  end

  // RULE_07: hold freezes pad state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_q <= 1'b0;
      pull_up_q <= 1'b0;
      pull_dn_q <= 1'b0;
      keep_en_q <= 1'b0;
    end else if (!hold_bit) begin
      pad_out_q <= src_out;
      pull_up_q <= (pull_sel == gpc_pkg::GPC_PULL_UP);
      pull_dn_q <= (pull_sel == gpc_pkg::GPC_PULL_DOWN);
      // RULE_09: keeper on undriven pad.
      keep_en_q <= keep_bit & ~src_oe;
    end
  end

  // RULE_08: sleep kill overrides hold.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_oe_q <= 1'b0;
    end else if (oe_kill) begin
      pad_oe_q <= 1'b0;
    end else if (!hold_bit) begin
      // RULE_05: tristate by output enable.
      pad_oe_q <= src_oe;
    end
  end

endmodule : gpc_pin

`default_nettype wire

/* File: rtl/gpc_top.sv */
// Behaviour
// RULE_01: Seventeen software-configured general-purpose pins.
// RULE_02: Per-pin pull-up, pull-down or floating.
// RULE_03: Input pin level captured into readable register.
// RULE_04: Per-pin interrupt, edge or level triggered.
// RULE_05: Non-inverting pads with per-pin output enable.
// RULE_06: Each pin routable to peripheral function.
// RULE_07: Per-pin hold freezes current pad state.
// RULE_08: Output enables forced low during sleep.
// RULE_09: Weak keeper retains level of undriven pad. Here pads undriven only by the sleep kill get no keeper.
// RULE_10: Inputs pass two synchroniser flip-flops.
// RULE_11: Edge status sticky; level status follows level. Here level status also stays set until a write-one clear.
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

// Pad bank controller with a classic Wishbone register slave.
module gpc_top #(
  parameter int N = `GPC_NPINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N-1:0] pad_in,
  output logic [N-1:0] pad_out,
  output logic [N-1:0] pad_oe,
  output logic [N-1:0] pad_pull_up,
  output logic [N-1:0] pad_pull_dn,
  output logic [N-1:0] pad_keep_en,
  input wire logic [N-1:0] periph_out,
  input wire logic [N-1:0] periph_oe,
  output logic [N-1:0] periph_in,
  input wire logic sleep_i,
  output logic irq
);

  // Writable configuration registers, one bit per pin, and the 32-bit control register.
  logic [N-1:0] out_q;
  logic [N-1:0] oe_q;
  logic [N-1:0] pu_q;
  logic [N-1:0] pd_q;
  logic [N-1:0] func_q;
  logic [N-1:0] hold_q;
  logic [N-1:0] keep_q;
  logic [N-1:0] lvl_q;
  logic [N-1:0] pol_q;
  logic [N-1:0] int_mask_q;
  logic [31:0] ctrl_q;
  // Captured input levels and sticky interrupt status.
  logic [N-1:0] in_data_q;
  logic [N-1:0] int_stat_q;
  logic [N-1:0] int_stat_d;
  // Per-pin event strobes from the pad slices.
  logic [N-1:0] pin_event;
  // Sleep request synchroniser.
  logic sleep_s1_q;
  logic sleep_s2_q;

  // A request is live while cycle and strobe are both high.
  wire logic bus_req = wb_cyc_i & wb_stb_i;
  // The write takes effect at the edge where the master sees ack.
  wire logic wr_fire = bus_req & wb_we_i & wb_ack_o;
  // Byte lanes expanded to a bit mask.
  wire logic [31:0] wr_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                               {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Address decode for each word.
  wire logic [5:0] word = wb_adr_i[7:2];
  wire logic hit_out = (word == 6'(`GPC_OFS_OUT >> 2));
  wire logic hit_oe = (word == 6'(`GPC_OFS_OE >> 2));
  wire logic hit_in = (word == 6'(`GPC_OFS_IN >> 2));
  wire logic hit_pu = (word == 6'(`GPC_OFS_PULLUP >> 2));
  wire logic hit_pd = (word == 6'(`GPC_OFS_PULLDN >> 2));
  wire logic hit_func = (word == 6'(`GPC_OFS_FUNC >> 2));
  wire logic hit_hold = (word == 6'(`GPC_OFS_HOLD >> 2));
  wire logic hit_keep = (word == 6'(`GPC_OFS_KEEP >> 2));
  wire logic hit_lvl = (word == 6'(`GPC_OFS_LVL >> 2));
  wire logic hit_pol = (word == 6'(`GPC_OFS_POL >> 2));
  wire logic hit_stat = (word == 6'(`GPC_OFS_STAT >> 2));
  wire logic hit_mask = (word == 6'(`GPC_OFS_MASK >> 2));
  wire logic hit_ctrl = (word == 6'(`GPC_OFS_CTRL >> 2));

  // Write-one-to-clear vector for the status register.
  wire logic [31:0] clr_word = wb_dat_i & wr_mask;
  wire logic [N-1:0] clr_vec = (wr_fire && hit_stat) ? clr_word[N-1:0] :
                               '0;
  // Sleep kill of every output enable.
  wire logic oe_kill = ctrl_q[`GPC_CTRL_KILL_BIT] & sleep_s2_q;

  // Read data selection; unmapped words read as zero.
  wire logic [31:0] rd_word =
    hit_out ? 32'(out_q) :
    hit_oe ? 32'(oe_q) :
    hit_in ? 32'(in_data_q) :
    hit_pu ? 32'(pu_q) :
    hit_pd ? 32'(pd_q) :
    hit_func ? 32'(func_q) :
    hit_hold ? 32'(hold_q) :
    hit_keep ? 32'(keep_q) :
    hit_lvl ? 32'(lvl_q) :
    hit_pol ? 32'(pol_q) :
    hit_stat ? 32'(int_stat_q) :
    hit_mask ? 32'(int_mask_q) :
    hit_ctrl ? ctrl_q : 32'h0000_0000;

  // Merges write data into a register through the byte lanes.
  function automatic logic [N-1:0] merge(input logic [N-1:0] old,
                                         input logic [31:0] dat,
                                         input logic [31:0] wm);
    logic [31:0] full;
    full = (32'(old) & ~wm) | (dat & wm);
    return full[N-1:0];
  endfunction : merge

  // Ack rises one cycle after the request and drops the cycle after.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      wb_dat_o <= (bus_req & ~wb_ack_o) ? rd_word : wb_dat_o;
    end
  end

  // RULE_05: output value and enable registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= N'(`GPC_RST_VAL);
      oe_q <= N'(`GPC_RST_VAL);
    end else begin
      if (wr_fire && hit_out) begin
        out_q <= merge(out_q, wb_dat_i, wr_mask);
      end
      if (wr_fire && hit_oe) begin
        oe_q <= merge(oe_q, wb_dat_i, wr_mask);
      end
    end
  end

  // RULE_02: pull resistor registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pu_q <= N'(`GPC_RST_VAL);
      pd_q <= N'(`GPC_RST_VAL);
    end else begin
      if (wr_fire && hit_pu) begin
        pu_q <= merge(pu_q, wb_dat_i, wr_mask);
      end
      if (wr_fire && hit_pd) begin
        pd_q <= merge(pd_q, wb_dat_i, wr_mask);
      end
    end
  end

  // RULE_06: function select register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      func_q <= N'(`GPC_RST_VAL);
    end else if (wr_fire && hit_func) begin
      func_q <= merge(func_q, wb_dat_i, wr_mask);
    end
  end

  // RULE_07 and RULE_09: hold and keeper registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= N'(`GPC_RST_VAL);
      keep_q <= N'(`GPC_RST_VAL);
    end else begin
      if (wr_fire && hit_hold) begin
        hold_q <= merge(hold_q, wb_dat_i, wr_mask);
      end
      if (wr_fire && hit_keep) begin
        keep_q <= merge(keep_q, wb_dat_i, wr_mask);
      end
    end
  end

  // RULE_04: trigger mode, polarity and mask registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= N'(`GPC_RST_VAL);
      pol_q <= N'(`GPC_RST_VAL);
      int_mask_q <= N'(`GPC_RST_VAL);
    end else begin
      if (wr_fire && hit_lvl) begin
        lvl_q <= merge(lvl_q, wb_dat_i, wr_mask);
      end
      if (wr_fire && hit_pol) begin
        pol_q <= merge(pol_q, wb_dat_i, wr_mask);
      end
      if (wr_fire && hit_mask) begin
        int_mask_q <= merge(int_mask_q, wb_dat_i, wr_mask);
      end
    end
  end

  // Control register; only the kill bit is implemented.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `GPC_RST_VAL;
    end else if (wr_fire && hit_ctrl) begin
      ctrl_q[`GPC_CTRL_KILL_BIT] <= wb_dat_i[`GPC_CTRL_KILL_BIT] &
                                   wb_sel_i[0];
    end
  end

  // RULE_10: sleep request synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      sleep_s1_q <= sleep_i;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // RULE_03: capture synchronised level of input pins.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_data_q <= N'(`GPC_RST_VAL);
    end else begin
      in_data_q <= (in_data_q & pad_oe) | (periph_in & ~pad_oe);
    end
  end

  // RULE_11: a new event wins over a clear in the same cycle.
  assign int_stat_d = (int_stat_q & ~clr_vec) | pin_event;

  // Sticky status and the masked interrupt level.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= N'(`GPC_RST_VAL);
      irq <= 1'b0;
    end else begin
      int_stat_q <= int_stat_d;
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // RULE_01: one pad slice per pin.
  for (genvar i = 0; i < N; i++) begin : g_pin
    gpc_pin u_pin (
      .clk(clk),
      .rst_n(rst_n),
      .pad_in(pad_in[i]),
      .out_bit(out_q[i]),
      .oe_bit(oe_q[i]),
      .pu_bit(pu_q[i]),
      .pd_bit(pd_q[i]),
      .func_bit(func_q[i]),
      .periph_out(periph_out[i]),
      .periph_oe(periph_oe[i]),
      .hold_bit(hold_q[i]),
      .keep_bit(keep_q[i]),
      .lvl_bit(lvl_q[i]),
      .pol_bit(pol_q[i]),
      .oe_kill(oe_kill),
      .pad_out_q(pad_out[i]),
      .pad_oe_q(pad_oe[i]),
      .pull_up_q(pad_pull_up[i]),
      .pull_dn_q(pad_pull_dn[i]),
      .keep_en_q(pad_keep_en[i]),
      .in_sync_q(periph_in[i]),
      .event_q(pin_event[i])
    );
  end

  // Ack is a single-cycle answer.
  AST_ACK_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack stayed high for two cycles.");

  // A fresh request is answered on the next cycle.
  AST_ACK_LAT: assert property (@(posedge clk) disable iff (!rst_n)
    (bus_req && !wb_ack_o) |=> wb_ack_o)
    else $error("Ack did not follow a request.");

  // A sleep kill clears every output enable at the next edge.
  AST_OE_KILL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    oe_kill |=> (pad_oe == '0))
    else $error("Output enable not forced low in sleep.");

  // A held pin keeps its output value.
  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    ##1 (((pad_out ^ $past(pad_out)) & $past(hold_q)) == '0))
    else $error("Held pad output changed.");

  // The two resistors never fight each other.
  AST_PULL: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    (pad_pull_up & pad_pull_dn) == '0)
    else $error("Pull-up and pull-down both on.");

  AST_MUX: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    ##1 (((pad_out ^ $past((func_q & periph_out) | (~func_q & out_q)))
      & ~$past(hold_q)) == '0))
    else $error("Pad output does not follow its selected source.");

  // The pad level reaches the core exactly two edges late.
  AST_SYNC: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    ##2 (periph_in == $past(pad_in, 2)))
    else $error("Input not delayed by two synchroniser stages.");

  // Undriven pins load their synchronised level into the input register.
  AST_IN_CAP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    ##1 (((in_data_q ^ $past(periph_in)) & ~$past(pad_oe)) == '0))
    else $error("Input register missed the pin level.");

  // A status bit only drops through a write-one clear.
  AST_STICKY: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    ##1 ((($past(int_stat_q) & ~$past(clr_vec)) & ~int_stat_q) == '0))
    else $error("Status bit dropped without a clear.");

  // The interrupt line follows the masked status one edge later.
  AST_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    ##1 (irq == $past(|(int_stat_q & int_mask_q))))
    else $error("Interrupt output disagrees with masked status.");

  // Every pin event lands in its status bit one edge later.
  AST_EVT_SET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    ##1 (($past(pin_event) & ~int_stat_q) == '0))
    else $error("Pin event did not set its status bit.");

  // A driven pad never has its keeper switched on as well.
  AST_KEEP: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    (pad_keep_en & pad_oe) == '0)
    else $error("Keeper enabled on a driven pad.");

  // Bits above the last pin always read as zero.
  AST_RD_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    wb_ack_o |-> (wb_dat_o[31:N] == '0))
    else $error("Read data has bits set above the last pin.");

endmodule : gpc_top

`default_nettype wire

/* File: tb/gpc_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Board side of the pads: outside drivers, resistors and weak keeper.
module gpc_pad_model #(
  parameter int N = 17
) (
  input wire logic clk,
  input wire logic [N-1:0] pad_out,
  input wire logic [N-1:0] pad_oe,
  input wire logic [N-1:0] pull_up,
  input wire logic [N-1:0] pull_dn,
  input wire logic [N-1:0] keep_en,
  input wire logic [N-1:0] ext_en,
  input wire logic [N-1:0] ext_val,
  output logic [N-1:0] pad_in
);
  logic [N-1:0] last_q; // Level of each pad one cycle ago.

  // Resolves each pad; a floating pad toggles so no stale level is seen.
  // pad level resolution
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pull_up[i]) begin
        pad_in[i] = 1'b1;
      end else if (pull_dn[i]) begin
        pad_in[i] = 1'b0;
      end else if (keep_en[i]) begin
        pad_in[i] = last_q[i];
      end else begin
        pad_in[i] = ~last_q[i];
      end
    end
  end

  // Remembers the last level for the keeper.
  always @(posedge clk) begin
    last_q <= pad_in;
  end
endmodule : gpc_pad_model

`default_nettype wire

/* File: tb/tb_gpio_pad_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "gpc_regs.svh"

// Register-level test of the pad bank with a board model on the pads.
module tb_gpio_pad_controller;
  logic clk, rst_n, cyc, stb, we, sleep, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [16:0] p_in, p_out, p_oe, pu, pd, kp, ext_en, ext_val;
  logic [16:0] per_out, per_oe, per_in;
  int n_mismatch = 0;
  int checked = 0;

  gpc_top u_dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in(p_in), .pad_out(p_out),
    .pad_oe(p_oe), .pad_pull_up(pu), .pad_pull_dn(pd), .pad_keep_en(kp),
    .periph_out(per_out), .periph_oe(per_oe), .periph_in(per_in),
    .sleep_i(sleep), .irq(irq)
  );

  gpc_pad_model u_pads (
    .clk(clk), .pad_out(p_out), .pad_oe(p_oe), .pull_up(pu),
    .pull_dn(pd), .keep_en(kp), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(p_in)
  );

  // Free-running system clock.
  always #4 clk = ~clk;

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Classic single Wishbone cycle; read data lands in q at the ack edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    // Holds the request until ack is seen high at a rising edge.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  // Lets n rising edges pass and returns at the next one, where the
  // outputs launched by them are settled.
  task automatic tick(input int n);
    repeat (n + 1) @(posedge clk);
  endtask : tick

  // Prints the counts and the verdict, then stops.
  task automatic test_done;
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Cuts a hang short.
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end

  // Main sequence.
  initial begin
    {clk, rst_n, cyc, stb, we, sleep, adr, sel, wdat} = '0;
    {ext_en, ext_val, per_out, per_oe} = '0;
    // Pads start driven low from outside so no stray edge is seen.
    ext_en = 17'h1_ffff;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 8'h30; a += 4) begin
      wb(1'b0, a[7:0], 32'h0);
      if (a != `GPC_OFS_IN) chk(q, 32'h0);
    end
    wb(1'b1, `GPC_OFS_OUT, 32'hffff_ffff);
    wb(1'b0, `GPC_OFS_OUT, 32'h0);
    chk(q, 32'h0001_ffff);
    wb(1'b1, `GPC_OFS_OUT, 32'h0000_a5a5);
    wb(1'b1, `GPC_OFS_OE, 32'h0001_ffff);
    tick(1);
    chk(p_out, 32'h0000_a5a5);
    chk(p_oe, 32'h0001_ffff);
    per_out <= 17'h1_2345;
    per_oe <= 17'h0_f0f0;
    wb(1'b1, `GPC_OFS_FUNC, 32'h0001_ffff);
    tick(1);
    chk(p_out, 32'h0001_2345);
    chk(p_oe, 32'h0000_f0f0);
    wb(1'b1, `GPC_OFS_FUNC, 32'h0);
    wb(1'b1, `GPC_OFS_HOLD, 32'h0001_ffff);
    wb(1'b1, `GPC_OFS_OUT, 32'h0);
    tick(2);
    chk(p_out, 32'h0000_a5a5);
    wb(1'b1, `GPC_OFS_CTRL, 32'h1);
    sleep <= 1'b1;
    tick(4);
    chk(p_oe, 32'h0);
    sleep <= 1'b0;
    wb(1'b1, `GPC_OFS_HOLD, 32'h0);
    wb(1'b1, `GPC_OFS_OE, 32'h0);
    tick(1);
    chk(p_out, 32'h0);
    // Pads float from here on; resistors and keeper set their level.
    ext_en <= 17'h0;
    wb(1'b1, `GPC_OFS_PULLUP, 32'h0000_000f);
    wb(1'b1, `GPC_OFS_PULLDN, 32'h0000_00ff);
    tick(1);
    chk(pu, 32'h0000_000f);
    chk(pd, 32'h0000_00f0);
    tick(4);
    wb(1'b0, `GPC_OFS_IN, 32'h0);
    chk(q & 32'hff, 32'h0000_000f);
    wb(1'b1, `GPC_OFS_KEEP, 32'h0001_ffff);
    wb(1'b1, `GPC_OFS_PULLDN, 32'h0);
    wb(1'b1, `GPC_OFS_PULLUP, 32'h0);
    tick(4);
    chk(kp, 32'h0001_ffff);
    wb(1'b0, `GPC_OFS_IN, 32'h0);
    chk(q & 32'hff, 32'h0000_000f);
    // Outside drivers overpower the keeper.
    ext_en <= 17'h1_ffff;
    wb(1'b1, `GPC_OFS_POL, 32'h1);
    wb(1'b1, `GPC_OFS_LVL, 32'h2);
    wb(1'b1, `GPC_OFS_MASK, 32'h1);
    wb(1'b1, `GPC_OFS_STAT, 32'h0001_ffff);
    wb(1'b0, `GPC_OFS_STAT, 32'h0);
    chk(q, 32'h2);
    @(posedge clk);
    ext_val <= 17'h0_0003;
    tick(1);
    chk(per_in, 32'h0);
    tick(1);
    chk(per_in, 32'h3);
    tick(4);
    chk(irq, 1'b1);
    wb(1'b0, `GPC_OFS_STAT, 32'h0);
    chk(q, 32'h3);
    ext_val <= 17'h0;
    tick(6);
    wb(1'b1, `GPC_OFS_STAT, 32'h3);
    wb(1'b0, `GPC_OFS_STAT, 32'h0);
    chk(q, 32'h2);
    chk(irq, 1'b0);
    wb(1'b1, `GPC_OFS_MASK, 32'h2);
    tick(2);
    chk(irq, 1'b1);
    ext_val <= 17'h0_0002;
    tick(6);
    wb(1'b1, `GPC_OFS_STAT, 32'h2);
    wb(1'b0, `GPC_OFS_STAT, 32'h0);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    wb(1'b0, 8'h3c, 32'h0);
    chk(q, 32'h0);
    test_done;
  end
endmodule : tb_gpio_pad_controller

`default_nettype wire
